// File: logic/led_output_stage_control.sv
// Per-channel LED output stage: duty waveforms, group dim/blink, polarity and pin drive
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module led_output_stage_control #(
  parameter int CHANNELS = 16,
  parameter int BLINK_STEP_CYCLES = led_stage_pkg::BLINK_STEP_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic outputEnableN,
  input wire logic outputPolarityInvert,
  input wire logic outputDriveType,
  input wire logic [1:0] disabledOutputState,
  input wire logic groupModeSelect,
  input wire logic [2*CHANNELS-1:0] channelStateSelect,
  input wire logic [led_stage_pkg::DUTY_WIDTH*CHANNELS-1:0] channelDuty,
  input wire logic [led_stage_pkg::DUTY_WIDTH-1:0] groupDuty,
  input wire logic [led_stage_pkg::DUTY_WIDTH-1:0] groupBlinkPeriod,
  output logic [CHANNELS-1:0] channelOutputPin,
  output logic [CHANNELS-1:0] channelOutputPinOeN
);

  localparam int DW = led_stage_pkg::DUTY_WIDTH;
  localparam int INDIV_STEPS = led_stage_pkg::INDIV_STEP_CYCLES;
  localparam int DIM_STEPS = led_stage_pkg::DIM_STEP_CYCLES;
  localparam int INDIV_PW = (INDIV_STEPS > 1) ? $clog2(INDIV_STEPS) : 1;
  localparam int DIM_PW = (DIM_STEPS > 1) ? $clog2(DIM_STEPS) : 1;
  localparam int BLINK_PW = (BLINK_STEP_CYCLES > 1) ? $clog2(BLINK_STEP_CYCLES) : 1;

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  generate
    if (CHANNELS < 1) begin : gBadChannels
      $error("CHANNELS must be at least 1");
    end
    if (BLINK_STEP_CYCLES < 1) begin : gBadBlink
      $error("BLINK_STEP_CYCLES must be at least 1");
    end
  endgenerate

  // ------------------------------------------------------------------
  // Individual waveform timebase
  // ------------------------------------------------------------------
  // One counter serves all channels, so every channel shares the same phase
  logic [INDIV_PW-1:0] indivPrescale;
  logic [DW-1:0] indivCount;
  wire logic indivStep;

  assign indivStep = (indivPrescale == INDIV_PW'(INDIV_STEPS - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      indivPrescale <= '0;
    end else if (indivStep) begin
      indivPrescale <= '0;
    end else begin
      indivPrescale <= indivPrescale + INDIV_PW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      indivCount <= '0;
    end else if (indivStep) begin
      indivCount <= indivCount + DW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Group dimming timebase
  // ------------------------------------------------------------------
  logic [DIM_PW-1:0] dimPrescale;
  logic [DW-1:0] dimCount;
  wire logic dimStep;

  assign dimStep = (dimPrescale == DIM_PW'(DIM_STEPS - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      dimPrescale <= '0;
    end else if (dimStep) begin
      dimPrescale <= '0;
    end else begin
      dimPrescale <= dimPrescale + DIM_PW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dimCount <= '0;
    end else if (dimStep) begin
      dimCount <= dimCount + DW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Group blinking timebase
  // ------------------------------------------------------------------
  // Each blink step lasts (period code + 1) base steps, so the period
  // scales linearly from the fastest rate down to 256 times slower.
  logic [BLINK_PW-1:0] blinkPrescale;
  logic [DW-1:0] blinkStretch;
  logic [DW-1:0] blinkCount;
  wire logic blinkBaseStep;
  wire logic blinkStretchDone;
  wire logic blinkStep;

  assign blinkBaseStep = (blinkPrescale == BLINK_PW'(BLINK_STEP_CYCLES - 1));
  // A lowered period code ends the current step at the next base step instead of wrapping
  assign blinkStretchDone = (blinkStretch >= groupBlinkPeriod);
  assign blinkStep = blinkBaseStep && blinkStretchDone;

  always_ff @(posedge mclk) begin
    if (rst) begin
      blinkPrescale <= '0;
    end else if (blinkBaseStep) begin
      blinkPrescale <= '0;
    end else begin
      blinkPrescale <= blinkPrescale + BLINK_PW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      blinkStretch <= '0;
    end else if (blinkStep) begin
      blinkStretch <= '0;
    end else if (blinkBaseStep) begin
      blinkStretch <= blinkStretch + DW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      blinkCount <= '0;
    end else if (blinkStep) begin
      blinkCount <= blinkCount + DW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Group waveform selection
  // ------------------------------------------------------------------
  wire logic [DW-1:0] groupCount;
  wire logic groupActive;
  wire logic outputsEnabled;

  assign groupCount = (groupModeSelect == led_stage_pkg::GROUP_MODE_BLINK)
                      ? blinkCount : dimCount;
  assign groupActive = (groupCount < groupDuty);
  assign outputsEnabled = !outputEnableN;

  // ------------------------------------------------------------------
  // Per-channel level and pin driver
  // ------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChannel
      wire logic [1:0] chanState;
      wire logic [DW-1:0] chanDuty;
      wire logic indivActive;
      logic pullLowPlain;
      pin_stage_if link ();

      assign chanState = channelStateSelect[2*ch +: 2];
      assign chanDuty = channelDuty[DW*ch +: DW];
      assign indivActive = (indivCount < chanDuty);

      // Level before inversion: high means the lower transistor is on
      always_comb begin
        case (chanState)
          led_stage_pkg::STATE_OFF: pullLowPlain = 1'b0;
          led_stage_pkg::STATE_ON: pullLowPlain = 1'b1;
          led_stage_pkg::STATE_INDIV: pullLowPlain = indivActive;
          led_stage_pkg::STATE_COMBINED: pullLowPlain = indivActive && groupActive;
          default: pullLowPlain = 1'b0;
        endcase
      end

      // Inversion complements every state, static and waveform alike
      assign link.pullLow = pullLowPlain ^ outputPolarityInvert;
      assign link.outputsEnabled = outputsEnabled;
      assign link.driveType = outputDriveType;
      assign link.disabledState = disabledOutputState;

      pin_driver_stage uStage (
        .mclk(mclk),
        .rst(rst),
        .link(link.stage),
        .pinOut(channelOutputPin[ch]),
        .pinOeN(channelOutputPinOeN[ch])
      );
    end
  endgenerate

endmodule : led_output_stage_control

// File: logic/led_stage_pkg.sv
// Constants shared by the LED output stage control block
package led_stage_pkg;

  // ------------------------------------------------------------------
  // Clock and waveform timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int DUTY_STEPS = 256;
  localparam int DUTY_WIDTH = 8;
  localparam int INDIV_FREQ_HZ = 97_000;
  localparam int DIM_FREQ_HZ = 190;
  localparam int BLINK_FAST_FREQ_HZ = 24;
  // Cycles per duty step; the waveform period is DUTY_STEPS steps
  localparam int INDIV_STEP_CYCLES = CLK_HZ / (INDIV_FREQ_HZ * DUTY_STEPS);
  localparam int DIM_STEP_CYCLES = CLK_HZ / (DIM_FREQ_HZ * DUTY_STEPS);
  // Step length of the fastest blink; slower blinks stretch it by (period code + 1)
  localparam int BLINK_STEP_CYCLES_DEFAULT = CLK_HZ / (BLINK_FAST_FREQ_HZ * DUTY_STEPS);

  // ------------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] STATE_OFF = 2'h0;
  localparam logic [1:0] STATE_ON = 2'h1;
  localparam logic [1:0] STATE_INDIV = 2'h2;
  localparam logic [1:0] STATE_COMBINED = 2'h3;

  localparam logic [1:0] DISABLED_LOW = 2'h0;
  localparam logic [1:0] DISABLED_HIGH = 2'h1;
  localparam logic [1:0] DISABLED_FLOAT = 2'h2;

  localparam logic GROUP_MODE_DIM = 1'h0;
  localparam logic GROUP_MODE_BLINK = 1'h1;

  localparam logic DRIVE_OPEN_DRAIN = 1'h0;
  localparam logic DRIVE_TOTEM_POLE = 1'h1;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RESET_PIN_OUT = 1'h1;
  localparam logic RESET_PIN_OE_N = 1'h1;

endpackage : led_stage_pkg

// File: logic/pin_driver_stage.sv
// Output transistor selection and registered pin drive for one channel
`timescale 1ns/1ps
module pin_driver_stage (
  input wire logic mclk,
  input wire logic rst,
  pin_stage_if.stage link,
  output logic pinOut,
  output logic pinOeN
);

  // ------------------------------------------------------------------
  // Transistor selection
  // ------------------------------------------------------------------
  wire logic highDriven;
  wire logic enabledOut;
  wire logic enabledOeN;
  wire logic disabledOut;
  wire logic disabledOeN;
  wire logic next_pinOut;
  wire logic next_pinOeN;

  // Open drain never turns on the upper transistor
  assign highDriven = (link.driveType == led_stage_pkg::DRIVE_TOTEM_POLE);
  assign enabledOut = !link.pullLow;
  assign enabledOeN = !(link.pullLow || highDriven);

  // Reserved code 11 floats like code 10
  assign disabledOut = (link.disabledState == led_stage_pkg::DISABLED_HIGH);
  assign disabledOeN = !((link.disabledState == led_stage_pkg::DISABLED_LOW)
                         || ((link.disabledState == led_stage_pkg::DISABLED_HIGH)
                             && highDriven));

  // Override acts in the very next cycle, no waveform boundary awaited
  assign next_pinOut = link.outputsEnabled ? enabledOut : disabledOut;
  assign next_pinOeN = link.outputsEnabled ? enabledOeN : disabledOeN;

  // ------------------------------------------------------------------
  // Pin registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinOut <= led_stage_pkg::RESET_PIN_OUT;
      pinOeN <= led_stage_pkg::RESET_PIN_OE_N;
    end else begin
      pinOut <= next_pinOut;
      pinOeN <= next_pinOeN;
    end
  end

endmodule : pin_driver_stage

// File: logic/pin_stage_if.sv
// Per-channel link between the waveform logic and one pin driver
`timescale 1ns/1ps
interface pin_stage_if;
  logic pullLow;
  logic outputsEnabled;
  logic driveType;
  logic [1:0] disabledState;

  modport ctrl (output pullLow, output outputsEnabled, output driveType, output disabledState);
  modport stage (input pullLow, input outputsEnabled, input driveType, input disabledState);
endinterface : pin_stage_if

// File: sim/led_load_model.sv
// Pin load model: LEDs with a pull-up resistor on every channel pin
`timescale 1ns/1ps
module led_load_model #(
  parameter int CHANNELS = 16
) (
  input wire logic [CHANNELS-1:0] pinOut,
  input wire logic [CHANNELS-1:0] pinOeN,
  output logic [CHANNELS-1:0] pinLevel
);
  // A released pin is pulled up, so it reads high, never a stale value
  assign pinLevel = pinOut | pinOeN;
endmodule : led_load_model

// File: sim/led_output_stage_control_tb.sv
// Self-checking bench for the LED output stage control block
`timescale 1ns/1ps
module led_output_stage_control_tb;
  localparam int CH = 2;
  localparam int BLINK = 2;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic enN = 1'b0;
  logic inv = 1'b0;
  logic drv = 1'b1;
  logic st = 1'b0;
  logic grpMode = 1'b0;
  logic [1:0] disState = 2'h0;
  logic [1:0] expPin;
  logic [2*CH-1:0] state = 4'h0;
  logic [8*CH-1:0] duty = 16'h0;
  logic [7:0] grpDuty = 8'h00;
  logic [7:0] blinkPer = 8'h00;
  logic [CH-1:0] pinOut;
  logic [CH-1:0] pinOeN;
  logic [CH-1:0] level;
  int errCount = 0;
  int checked = 0;
  int cycles = 0;
  int dv[4] = '{0, 1, 128, 255};
  int gMode[5] = '{0, 1, 1, 1, 0};
  int gDuty[5] = '{0, 128, 64, 0, 255};
  int gInv[5] = '{0, 0, 1, 0, 0};
  int gLow[5] = '{0, 512, 768, 0, 1020};

  always #5 mclk = ~mclk;

  led_output_stage_control #(.CHANNELS(CH), .BLINK_STEP_CYCLES(BLINK)) led_output_stage_control_i (
    .mclk(mclk), .rst(rst), .outputEnableN(enN), .outputPolarityInvert(inv),
    .outputDriveType(drv), .disabledOutputState(disState), .groupModeSelect(grpMode),
    .channelStateSelect(state), .channelDuty(duty), .groupDuty(grpDuty),
    .groupBlinkPeriod(blinkPer), .channelOutputPin(pinOut), .channelOutputPinOeN(pinOeN));
  led_load_model #(.CHANNELS(CH)) led_load_model_i (.pinOut(pinOut), .pinOeN(pinOeN),
    .pinLevel(level));

  // ------------------------------------------------------------------
  // Compare, measure and closing tasks
  // ------------------------------------------------------------------
  task automatic chkPin(input string name, input logic [1:0] expv, input logic [1:0] got);
    checked++;
    if (got !== expv) begin
      errCount++;
      $display("Error %s expected %h seen %h", name, expv, got);
    end
  endtask : chkPin

  task automatic chkCnt(input string name, input int expv, input int got);
    checked++;
    if (got != expv) begin
      errCount++;
      $display("Error %s expected %0d seen %0d", name, expv, got);
    end
  endtask : chkCnt

  // One full individual period; the window start phase does not matter
  task automatic lowCount(input int ch, input int expLow);
    int n;
    n = 0;
    @(negedge mclk);
    repeat (1024) begin
      @(negedge mclk);
      n += int'(level[ch] === 1'b0);
    end
    chkCnt("low cycles", expLow, n);
  endtask : lowCount

  // Group start is a fall after a long high run, so short individual gaps are skipped
  task automatic groupPeriod(input int ch, input int expPer);
    int run;
    int n;
    int first;
    run = 0;
    n = 0;
    first = -1;
    while (n < 4 * expPer) begin
      @(negedge mclk);
      n++;
      if (level[ch] === 1'b1) begin
        run++;
      end else begin
        if (run >= 16 && first >= 0) begin
          break;
        end
        if (run >= 16) begin
          first = n;
        end
        run = 0;
      end
    end
    chkCnt("blink period", expPer, n - first);
  endtask : groupPeriod

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 25000) begin
      errCount++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge mclk);
    chkPin("reset", {led_stage_pkg::RESET_PIN_OUT, led_stage_pkg::RESET_PIN_OE_N},
      {pinOut[0], pinOeN[0]});
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {inv, drv, st} = 3'(i);
      state = {2{1'b0, st}};
      @(negedge mclk);
      expPin = (st ^ inv) ? 2'h0 : {1'b1, !drv};
      chkPin("static", expPin, {pinOut[0], pinOeN[0]});
    end
    enN = 1'b1;
    state = 4'hA;
    duty = 16'h80FF;
    for (int i = 0; i < 8; i++) begin
      {disState, drv} = 3'(i);
      inv = disState[0];
      @(negedge mclk);
      expPin = disState == 2'h0 ? 2'h0 : (disState == 2'h1 ? {1'b1, !drv} : 2'h1);
      chkPin("disabled", expPin, {pinOut[1], pinOeN[1]});
    end
    // Disable again with the reserved code standing: pins float in the next cycle
    enN = 1'b0;
    @(negedge mclk);
    enN = 1'b1;
    @(negedge mclk);
    chkPin("float rise", 2'h1, {pinOut[0], pinOeN[0]});
    enN = 1'b0;
    drv = 1'b1;
    for (int i = 0; i < 8; i++) begin
      inv = 1'(i / 4);
      duty = 16'(dv[i % 4]);
      lowCount(0, inv ? 1024 - 4 * dv[i % 4] : 4 * dv[i % 4]);
    end
    state = 4'hF;
    duty = 16'h00FF;
    for (int i = 0; i < 5; i++) begin
      grpMode = 1'(gMode[i]);
      grpDuty = 8'(gDuty[i]);
      inv = 1'(gInv[i]);
      lowCount(0, gLow[i]);
    end
    lowCount(1, 0);
    grpMode = 1'b1;
    grpDuty = 8'h80;
    blinkPer = 8'h01;
    groupPeriod(0, 2 * led_stage_pkg::DUTY_STEPS * BLINK);
    end_of_test();
  end
endmodule : led_output_stage_control_tb

// File: sim/led_stage_monitor.sv
// Assertion checker on the LED output stage top-level ports
`timescale 1ns/1ps
module led_stage_monitor #(
  parameter int CHANNELS = 16,
  parameter int BLINK_STEP_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic outputEnableN,
  input wire logic outputPolarityInvert,
  input wire logic outputDriveType,
  input wire logic [1:0] disabledOutputState,
  input wire logic groupModeSelect,
  input wire logic [2*CHANNELS-1:0] channelStateSelect,
  input wire logic [8*CHANNELS-1:0] channelDuty,
  input wire logic [7:0] groupDuty,
  input wire logic [7:0] groupBlinkPeriod,
  input wire logic [CHANNELS-1:0] channelOutputPin,
  input wire logic [CHANNELS-1:0] channelOutputPinOeN
);
  // ------------------------------------------------------------------
  // Channel 0 stands for all channels in the state and duty checks
  // ------------------------------------------------------------------
  wire logic [1:0] state0 = channelStateSelect[1:0];
  wire logic live = !outputEnableN;
  wire logic zeroDuty = channelDuty[7:0] == 8'h00;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence driveLow;
    !channelOutputPin[0] && !channelOutputPinOeN[0];
  endsequence
  sequence floatRise;
    $rose(outputEnableN) ##0 disabledOutputState[1];
  endsequence
  dis_low_a: assert property (
    outputEnableN && disabledOutputState == 2'h0 |=> !(|channelOutputPin) && !(|channelOutputPinOeN))
    else $error("disabled low state wrong");
  dis_high_a: assert property (
    outputEnableN && disabledOutputState == 2'h1 |=> &channelOutputPin
    && channelOutputPinOeN == {CHANNELS{!$past(outputDriveType)}}) else $error("disabled high wrong");
  float_now_a: assert property (
    floatRise |=> &channelOutputPinOeN) else $error("disable override late");
  open_drain_a: assert property (
    live && !outputDriveType |=> &(channelOutputPinOeN | ~channelOutputPin))
    else $error("open drain drove high");
  on_low_a: assert property (
    live && state0 == 2'h1 && !outputPolarityInvert |=> driveLow) else $error("on state not low");
  inv_off_a: assert property (
    live && state0 == 2'h0 && outputPolarityInvert |=> driveLow) else $error("inverted off not low");
  totem_off_a: assert property (
    live && state0 == 2'h0 && !outputPolarityInvert && outputDriveType
    |=> channelOutputPin[0] && !channelOutputPinOeN[0]) else $error("off state not high");
  zero_duty_a: assert property (
    live && state0[1] && zeroDuty && !outputPolarityInvert |=> not driveLow)
    else $error("zero duty went low");
  inv_zero_a: assert property (
    live && state0[1] && zeroDuty && outputPolarityInvert |=> driveLow)
    else $error("inverted zero duty not low");
  group_zero_a: assert property (
    live && state0 == 2'h3 && groupDuty == 8'h00 && !outputPolarityInvert |=> not driveLow)
    else $error("combined state low with zero group duty");
endmodule : led_stage_monitor

bind led_output_stage_control led_stage_monitor #(.CHANNELS(CHANNELS),
  .BLINK_STEP_CYCLES(BLINK_STEP_CYCLES)) led_stage_monitor_i (.mclk(mclk), .rst(rst),
  .outputEnableN(outputEnableN), .outputPolarityInvert(outputPolarityInvert),
  .outputDriveType(outputDriveType), .disabledOutputState(disabledOutputState),
  .groupModeSelect(groupModeSelect), .channelStateSelect(channelStateSelect),
  .channelDuty(channelDuty), .groupDuty(groupDuty), .groupBlinkPeriod(groupBlinkPeriod),
  .channelOutputPin(channelOutputPin), .channelOutputPinOeN(channelOutputPinOeN));
